// ==== rtl/fcl_pkg.sv ====
/*
  fcl_pkg: constants, carriers and states of the fuse configuration loader.
  assumes: a single 200 MHz clock domain; byte-wide fuse and signature rows.
*/
`default_nettype none

package fcl_pkg;

  // ---------------------------------------------------------------
  // address map
  // ---------------------------------------------------------------
  localparam int unsigned FCL_ADDR_W   = 6;
  localparam int unsigned FCL_FUSE_N   = 11;
  localparam logic [5:0]  FCL_OFS_WDT  = 6'h00;
  localparam logic [5:0]  FCL_OFS_BOD  = 6'h01;
  localparam logic [5:0]  FCL_OFS_OSC  = 6'h02;
  localparam logic [5:0]  FCL_OFS_SYS0 = 6'h05;
  localparam logic [5:0]  FCL_OFS_SYS1 = 6'h06;
  localparam logic [5:0]  FCL_OFS_APP  = 6'h07;
  localparam logic [5:0]  FCL_OFS_BOOT = 6'h08;
  localparam logic [5:0]  FCL_OFS_KEY  = 6'h0a;
  localparam logic [5:0]  FCL_OFS_E16H = 6'h23;
  localparam logic [5:0]  FCL_OFS_E20L = 6'h24;
  localparam logic [5:0]  FCL_OFS_E20H = 6'h25;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned FCL_WDT_WIN_LSB  = 4;
  localparam int unsigned FCL_WDT_PER_LSB  = 0;
  localparam int unsigned FCL_BOD_LVL_LSB  = 5;
  localparam int unsigned FCL_BOD_SAMP_BIT = 4;
  localparam int unsigned FCL_BOD_ACT_LSB  = 2;
  localparam int unsigned FCL_BOD_SLP_LSB  = 0;
  localparam int unsigned FCL_OSC_LOCK_BIT = 7;
  localparam int unsigned FCL_OSC_FREQ_LSB = 0;

  // ---------------------------------------------------------------
  // encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] FCL_FREQ_16M     = 2'h1;
  localparam logic [1:0] FCL_FREQ_20M     = 2'h2;
  localparam logic [1:0] FCL_BOD_DISABLED = 2'h0;
  localparam logic [1:0] FCL_BOD_ENABLED  = 2'h1;
  localparam logic [1:0] FCL_BOD_SAMPLED  = 2'h2;
  localparam logic [1:0] FCL_BOD_STALLED  = 2'h3;
  localparam logic       FCL_SAMP_1KHZ    = 1'b0;
  localparam logic       FCL_SAMP_125HZ   = 1'b1;

  // ---------------------------------------------------------------
  // fuse contents after power-on
  // ---------------------------------------------------------------
  localparam logic [7:0] FCL_RST_WDT  = 8'h00;
  localparam logic [7:0] FCL_RST_BOD  = 8'h00;
  localparam logic [7:0] FCL_RST_OSC  = 8'h02;
  localparam logic [7:0] FCL_RST_SYS0 = 8'hc4;
  localparam logic [7:0] FCL_RST_SYS1 = 8'h07;
  localparam logic [7:0] FCL_RST_APP  = 8'h00;
  localparam logic [7:0] FCL_RST_BOOT = 8'h00;
  localparam logic [7:0] FCL_RST_KEY  = 8'h00;
  localparam logic [7:0] FCL_RST_NONE = 8'hff;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] window;
    logic [3:0] period;
  } fcl_wdt_s;

  typedef struct packed {
    logic [2:0] brownout_threshold;
    logic       brownout_sample_rate;
    logic [1:0] active_mode;
    logic [1:0] sleep_mode;
  } fcl_bod_s;

  typedef struct packed {
    logic       oscillator_trim_protect;
    logic [1:0] oscillator_frequency_choice;
    logic       run_16m;
    logic [7:0] oscillator_coarse_trim;
    logic [7:0] oscillator_temperature_trim;
  } fcl_osc_s;

  typedef enum logic [2:0] {
    FCL_ST_WDT,
    FCL_ST_BOD,
    FCL_ST_OSC,
    FCL_ST_DONE
  } fcl_state_e;

endpackage : fcl_pkg

`default_nettype wire

// ==== rtl/fcl_fuse_config_loader.sv ====
/*
  fcl_fuse_config_loader: fuse array, signature calibration bytes and the
  reset-time copy of fuse fields into watchdog, brown-out and oscillator
  target registers.
  assumes: all inputs synchronous to ref_clk; por_b asserted only for a
  power-on reset, rst_b for every reset (also during power-on).
*/
`default_nettype none

// Overview of operation
// - 16 MHz 5V error byte, read-only
// - 20 MHz 3V error byte at 0x24
// - 20 MHz 5V error byte at 0x25
// - reset copies fuse 7:4 to window
// - reset copies fuse 3:0 to period
// - brown-out reloaded only after power-on reset
// - fuse 7:5 loads brown-out threshold
// - fuse bit 4 loads sample rate
// - fuse 3:2 loads active/idle mode
// - fuse 1:0 loads sleep mode
// - oscillator bit 7 locks trim writes
// - frequency code picks 16 or 20 MHz
// - frequency code picks factory trim values
// - copy happens at end of start-up
// - new watchdog and oscillator fuse values act after next warm reset
// - both read; only programmer writes fuses

module fcl_fuse_config_loader #(
  parameter logic [7:0] ERR_16M_HIGH = 8'h00,
  parameter logic [7:0] ERR_20M_LOW  = 8'h00,
  parameter logic [7:0] ERR_20M_HIGH = 8'h00,
  parameter logic [7:0] CAL_16M_CRS  = 8'h00,
  parameter logic [7:0] CAL_16M_TMP  = 8'h00,
  parameter logic [7:0] CAL_20M_CRS  = 8'h00,
  parameter logic [7:0] CAL_20M_TMP  = 8'h00
) (
  input  wire  logic                     ref_clk,
  input  wire  logic                     rst_b,
  input  wire  logic                     por_b,
  // cpu read port
  input  wire  logic                     cpu_rd,
  input  wire  logic [5:0]               cpu_addr,
  output logic       [7:0]               cpu_rdata,
  // programming and debug interface port
  input  wire  logic                     prog_rd,
  input  wire  logic                     prog_wr,
  input  wire  logic [5:0]               prog_addr,
  input  wire  logic [7:0]               prog_wdata,
  output logic       [7:0]               prog_rdata,
  // software writes to the oscillator trim registers
  input  wire  logic                     trim_wr,
  input  wire  logic [7:0]               trim_coarse_wdata,
  input  wire  logic [7:0]               trim_temp_wdata,
  // loaded targets
  output fcl_pkg::fcl_wdt_s              watchdog_control,
  output fcl_pkg::fcl_bod_s              brownout_control,
  output fcl_pkg::fcl_osc_s              oscillator_control,
  output logic                           cpu_rst_hold
);

  // ---------------------------------------------------------------
  // fuse array
  // ---------------------------------------------------------------
  logic [7:0] fuse_q [fcl_pkg::FCL_FUSE_N];

  wire        prog_hit_fuse;
  wire        prog_hit_used;
  wire  [3:0] prog_idx;

  assign prog_idx      = prog_addr[3:0];
  assign prog_hit_fuse = (prog_addr < 6'(fcl_pkg::FCL_FUSE_N));
  assign prog_hit_used = prog_hit_fuse &&
                         (prog_addr != 6'h03) &&
                         (prog_addr != 6'h04) &&
                         (prog_addr != 6'h09);

  // fuses are nonvolatile: only power-on returns them to defaults
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      fuse_q[0]  <= fcl_pkg::FCL_RST_WDT;
      fuse_q[1]  <= fcl_pkg::FCL_RST_BOD;
      fuse_q[2]  <= fcl_pkg::FCL_RST_OSC;
      fuse_q[3]  <= fcl_pkg::FCL_RST_NONE;
      fuse_q[4]  <= fcl_pkg::FCL_RST_NONE;
      fuse_q[5]  <= fcl_pkg::FCL_RST_SYS0;
      fuse_q[6]  <= fcl_pkg::FCL_RST_SYS1;
      fuse_q[7]  <= fcl_pkg::FCL_RST_APP;
      fuse_q[8]  <= fcl_pkg::FCL_RST_BOOT;
      fuse_q[9]  <= fcl_pkg::FCL_RST_NONE;
      fuse_q[10] <= fcl_pkg::FCL_RST_KEY;
    end else if (prog_wr && prog_hit_used) begin
      // only the programming port writes; value kept as written
      fuse_q[prog_idx] <= prog_wdata;
    end
  end

  // ---------------------------------------------------------------
  // read decode, shared by both readers
  // ---------------------------------------------------------------
  function automatic logic [7:0] fcl_read(
    input logic [5:0] addr,
    input logic [7:0] fuse_byte
  );
    logic [7:0] val;
    val = 8'h00;
    case (addr)
      fcl_pkg::FCL_OFS_WDT,
      fcl_pkg::FCL_OFS_BOD,
      fcl_pkg::FCL_OFS_OSC,
      fcl_pkg::FCL_OFS_SYS0,
      fcl_pkg::FCL_OFS_SYS1,
      fcl_pkg::FCL_OFS_APP,
      fcl_pkg::FCL_OFS_BOOT,
      fcl_pkg::FCL_OFS_KEY:  val = fuse_byte;
      fcl_pkg::FCL_OFS_E16H: val = ERR_16M_HIGH;
      fcl_pkg::FCL_OFS_E20L: val = ERR_20M_LOW;
      fcl_pkg::FCL_OFS_E20H: val = ERR_20M_HIGH;
      default:               val = 8'h00;
    endcase
    return val;
  endfunction : fcl_read

  wire  [3:0] cpu_idx;
  wire  [7:0] cpu_fuse_byte;
  wire  [7:0] prog_fuse_byte;
  wire  [7:0] cpu_rd_val;
  wire  [7:0] prog_rd_val;

  assign cpu_idx        = cpu_addr[3:0];
  assign cpu_fuse_byte  = (cpu_addr < 6'(fcl_pkg::FCL_FUSE_N)) ?
                          fuse_q[cpu_idx] : 8'h00;
  assign prog_fuse_byte = prog_hit_fuse ? fuse_q[prog_idx] : 8'h00;
  assign cpu_rd_val     = fcl_read(cpu_addr, cpu_fuse_byte);
  assign prog_rd_val    = fcl_read(prog_addr, prog_fuse_byte);

  // both readers see the same map
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_rdata  <= 8'h00;
      prog_rdata <= 8'h00;
    end else begin
      if (cpu_rd) begin
        cpu_rdata <= cpu_rd_val;
      end
      if (prog_rd) begin
        prog_rdata <= prog_rd_val;
      end
    end
  end

  // ---------------------------------------------------------------
  // load sequencer
  // ---------------------------------------------------------------
  fcl_pkg::fcl_state_e state_q;
  fcl_pkg::fcl_state_e state_d;

  always_comb begin
    state_d = state_q;
    case (state_q)
      fcl_pkg::FCL_ST_WDT:  state_d = fcl_pkg::FCL_ST_BOD;
      fcl_pkg::FCL_ST_BOD:  state_d = fcl_pkg::FCL_ST_OSC;
      fcl_pkg::FCL_ST_OSC:  state_d = fcl_pkg::FCL_ST_DONE;
      fcl_pkg::FCL_ST_DONE: state_d = fcl_pkg::FCL_ST_DONE;
      default:              state_d = fcl_pkg::FCL_ST_WDT;
    endcase
  end

  // sequence restarts on every reset, runs once after release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= fcl_pkg::FCL_ST_WDT;
    end else begin
      state_q <= state_d;
    end
  end

  logic hold_q;

  // released only once every target is loaded
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_q <= 1'b1;
    end else if (state_q == fcl_pkg::FCL_ST_OSC) begin
      hold_q <= 1'b0;
    end
  end

  assign cpu_rst_hold = hold_q;

  wire load_wdt;
  wire load_bod;
  wire load_osc;

  assign load_wdt = (state_q == fcl_pkg::FCL_ST_WDT);
  assign load_bod = (state_q == fcl_pkg::FCL_ST_BOD);
  assign load_osc = (state_q == fcl_pkg::FCL_ST_OSC);

  // ---------------------------------------------------------------
  // watchdog target
  // ---------------------------------------------------------------
  wire  [7:0]       wdt_fuse;
  fcl_pkg::fcl_wdt_s wdt_q;

  assign wdt_fuse = fuse_q[fcl_pkg::FCL_OFS_WDT[3:0]];

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_q <= '0;
    end else if (load_wdt) begin
      wdt_q.window <= wdt_fuse[fcl_pkg::FCL_WDT_WIN_LSB +: 4];
      wdt_q.period <= wdt_fuse[fcl_pkg::FCL_WDT_PER_LSB +: 4];
    end
  end

  assign watchdog_control = wdt_q;

  // ---------------------------------------------------------------
  // brown-out target, kept across every reset but power-on
  // ---------------------------------------------------------------
  wire  [7:0]       bod_fuse;
  fcl_pkg::fcl_bod_s bod_q;
  logic             por_pend_q;

  assign bod_fuse = fuse_q[fcl_pkg::FCL_OFS_BOD[3:0]];

  // marks a power-on; consumed by the brown-out load step
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      por_pend_q <= 1'b1;
    end else if (load_bod) begin
      por_pend_q <= 1'b0;
    end
  end

  // por_b only: a warm reset leaves this configuration alone
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      bod_q <= '0;
    end else if (load_bod && por_pend_q) begin
      bod_q.brownout_threshold   <=
        bod_fuse[fcl_pkg::FCL_BOD_LVL_LSB +: 3];
      bod_q.brownout_sample_rate <=
        bod_fuse[fcl_pkg::FCL_BOD_SAMP_BIT];
      bod_q.active_mode          <=
        bod_fuse[fcl_pkg::FCL_BOD_ACT_LSB +: 2];
      bod_q.sleep_mode           <=
        bod_fuse[fcl_pkg::FCL_BOD_SLP_LSB +: 2];
    end
  end

  assign brownout_control = bod_q;

  // ---------------------------------------------------------------
  // oscillator target
  // ---------------------------------------------------------------
  wire  [7:0]       osc_fuse;
  wire  [1:0]       freq_code;
  wire              pick_16m;
  wire  [7:0]       fac_coarse;
  wire  [7:0]       fac_temp;
  wire              trim_wr_ok;
  fcl_pkg::fcl_osc_s osc_q;

  assign osc_fuse   = fuse_q[fcl_pkg::FCL_OFS_OSC[3:0]];
  assign freq_code  = osc_fuse[fcl_pkg::FCL_OSC_FREQ_LSB +: 2];
  // reserved codes fall back to 20 MHz
  assign pick_16m   = (freq_code == fcl_pkg::FCL_FREQ_16M);
  assign fac_coarse = pick_16m ? CAL_16M_CRS : CAL_20M_CRS;
  assign fac_temp   = pick_16m ? CAL_16M_TMP : CAL_20M_TMP;
  assign trim_wr_ok = trim_wr && !osc_q.oscillator_trim_protect &&
                      (state_q == fcl_pkg::FCL_ST_DONE);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_q <= '0;
    end else if (load_osc) begin
      osc_q.oscillator_trim_protect     <=
        osc_fuse[fcl_pkg::FCL_OSC_LOCK_BIT];
      osc_q.oscillator_frequency_choice <= freq_code;
      osc_q.run_16m                     <= pick_16m;
      osc_q.oscillator_coarse_trim      <= fac_coarse;
      osc_q.oscillator_temperature_trim <= fac_temp;
    end else if (trim_wr_ok) begin
      osc_q.oscillator_coarse_trim      <= trim_coarse_wdata;
      osc_q.oscillator_temperature_trim <= trim_temp_wdata;
    end
  end

  // targets change only in load steps or, for the oscillator trims, on trim writes; never on fuse reads
  assign oscillator_control = osc_q;

endmodule : fcl_fuse_config_loader

`default_nettype wire

// ==== sim/fcl_monitor.sv ====
/*
  fcl_monitor: hold release, loaded values, trim writes and read checks on the loader.
  assumes: bound into fcl_fuse_config_loader; one clock, ref_clk.
*/
`default_nettype none

module fcl_monitor (
  input wire logic              ref_clk,
  input wire logic              rst_b,
  input wire logic              por_b,
  input wire logic              cpu_rd,
  input wire logic [5:0]        cpu_addr,
  input wire logic [7:0]        cpu_rdata,
  input wire logic              prog_rd,
  input wire logic              prog_wr,
  input wire logic [5:0]        prog_addr,
  input wire logic [7:0]        prog_wdata,
  input wire logic [7:0]        prog_rdata,
  input wire logic              trim_wr,
  input wire logic [7:0]        trim_coarse_wdata,
  input wire logic [7:0]        trim_temp_wdata,
  input wire fcl_pkg::fcl_wdt_s watchdog_control,
  input wire fcl_pkg::fcl_bod_s brownout_control,
  input wire fcl_pkg::fcl_osc_s oscillator_control,
  input wire logic              cpu_rst_hold
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] wdt_q;
  logic [7:0] bod_q;
  logic [7:0] osc_q;
  logic       pend_q;

  // fuse mirror, returned to defaults by power-on like the array
  always_ff @(posedge ref_clk or negedge por_b) begin
    if (!por_b) begin
      wdt_q  <= fcl_pkg::FCL_RST_WDT;
      bod_q  <= fcl_pkg::FCL_RST_BOD;
      osc_q  <= fcl_pkg::FCL_RST_OSC;
      pend_q <= 1'h1;
    end else begin
      if (prog_wr && prog_addr == fcl_pkg::FCL_OFS_WDT) wdt_q <= prog_wdata;
      if (prog_wr && prog_addr == fcl_pkg::FCL_OFS_BOD) bod_q <= prog_wdata;
      if (prog_wr && prog_addr == fcl_pkg::FCL_OFS_OSC) osc_q <= prog_wdata;
      if (!cpu_rst_hold) pend_q <= 1'h0;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  hold_release_a: assert property ($rose(rst_b) |->
    cpu_rst_hold [*2] ##[1:2] !cpu_rst_hold) else $error("hold not released");
  wdt_load_a: assert property ($fell(cpu_rst_hold) |->
    watchdog_control == wdt_q) else $error("watchdog load wrong");
  bod_load_a: assert property (
    $fell(cpu_rst_hold) && pend_q |-> brownout_control == bod_q)
    else $error("brownout load wrong");
  bod_keep_a: assert property (disable iff (!por_b)
    $changed(brownout_control) |-> pend_q) else $error("brownout reloaded");
  osc_load_a: assert property (
    $fell(cpu_rst_hold) |-> oscillator_control[19:16] ==
    {osc_q[7], osc_q[1:0], osc_q[1:0] == fcl_pkg::FCL_FREQ_16M})
    else $error("oscillator load wrong");
  cfg_stable_a: assert property (
    !cpu_rst_hold ##1 !cpu_rst_hold |-> $stable(watchdog_control) &&
    $stable(brownout_control) && $stable(oscillator_control[19:16]))
    else $error("loaded value moved");
  trim_lock_a: assert property (
    trim_wr && !cpu_rst_hold && oscillator_control[19] |=>
    $stable(oscillator_control)) else $error("locked trim written");
  trim_open_a: assert property (
    trim_wr && !cpu_rst_hold && !oscillator_control[19] |=>
    oscillator_control[15:8] == $past(trim_coarse_wdata) &&
    oscillator_control[7:0] == $past(trim_temp_wdata))
    else $error("trim write lost");
  fuse_read_a: assert property (
    prog_rd && !prog_wr && prog_addr == fcl_pkg::FCL_OFS_OSC |=>
    prog_rdata == osc_q) else $error("fuse read wrong");
endmodule : fcl_monitor

bind fcl_fuse_config_loader fcl_monitor u_monitor (
  .ref_clk(ref_clk), .rst_b(rst_b), .por_b(por_b), .cpu_rd(cpu_rd),
  .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .prog_rd(prog_rd),
  .prog_wr(prog_wr), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
  .prog_rdata(prog_rdata), .trim_wr(trim_wr),
  .trim_coarse_wdata(trim_coarse_wdata), .trim_temp_wdata(trim_temp_wdata),
  .watchdog_control(watchdog_control), .brownout_control(brownout_control),
  .oscillator_control(oscillator_control), .cpu_rst_hold(cpu_rst_hold)
);

`default_nettype wire

// ==== sim/fcl_programmer.sv ====
/*
  fcl_programmer: model of the programming interface side of the fuses.
  assumes: tasks are entered just after a rising edge of ref_clk.
*/
`default_nettype none

module fcl_programmer (
  input  wire logic       ref_clk,
  output logic            prog_rd,
  output logic            prog_wr,
  output logic [5:0]      prog_addr,
  output logic [7:0]      prog_wdata,
  input  wire logic [7:0] prog_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    prog_rd    = 1'h0;
    prog_wr    = 1'h0;
    prog_addr  = 6'h3f;
    prog_wdata = 8'h00;
  end

  // reserved bits of each fuse byte, always written as one
  function automatic logic [7:0] rsv_mask(input logic [5:0] a);
    case (a)
      fcl_pkg::FCL_OFS_OSC:  rsv_mask = 8'h7c;
      fcl_pkg::FCL_OFS_SYS0: rsv_mask = 8'h32;
      fcl_pkg::FCL_OFS_SYS1: rsv_mask = 8'hf8;
      6'h03, 6'h04, 6'h09:   rsv_mask = 8'hff;
      default:               rsv_mask = 8'h00;
    endcase
  endfunction : rsv_mask

  task automatic wr(input logic w, input logic [5:0] a, input logic [7:0] d);
    if (w) @(posedge ref_clk);
    prog_wr    <= 1'h1;
    prog_addr  <= a;
    prog_wdata <= d | rsv_mask(a);
    @(posedge ref_clk);
    prog_wr    <= 1'h0;
    prog_addr  <= ~a;
    prog_wdata <= ~d;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    prog_rd   <= 1'h1;
    prog_addr <= a;
    @(posedge ref_clk);
    prog_rd   <= 1'h0;
    prog_addr <= ~a;
    @(negedge ref_clk);
    d = prog_rdata;
  endtask : rd
endmodule : fcl_programmer

`default_nettype wire

// ==== sim/fcl_fuse_config_loader_test.sv ====
/*
  fcl_fuse_config_loader_test: random fuse contents across warm and
  power-on resets, signature reads, trim writes with and without lock.
  assumes: fcl_monitor bound in; fcl_programmer drives the prog port.
*/
`default_nettype none

module fcl_fuse_config_loader_test;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [7:0] C16C = 8'h31;
  localparam logic [7:0] C16T = 8'h32;
  localparam logic [7:0] C20C = 8'h41;
  localparam logic [7:0] C20T = 8'h42;

  logic              ref_clk, rst_b, por_b, cpu_rd, trim_wr, cpu_rst_hold;
  logic              prog_rd, prog_wr;
  logic [5:0]        cpu_addr, prog_addr;
  logic [7:0]        cpu_rdata, prog_wdata, prog_rdata;
  logic [7:0]        trim_coarse_wdata, trim_temp_wdata;
  fcl_pkg::fcl_wdt_s watchdog_control;
  fcl_pkg::fcl_bod_s brownout_control;
  fcl_pkg::fcl_osc_s oscillator_control;
  int                err_count = 0;
  int                n_tests = 0;
  int                cycles = 0;

  fcl_fuse_config_loader #(.ERR_16M_HIGH(8'h91), .ERR_20M_LOW(8'h92),
    .ERR_20M_HIGH(8'h93), .CAL_16M_CRS(C16C), .CAL_16M_TMP(C16T),
    .CAL_20M_CRS(C20C), .CAL_20M_TMP(C20T)) DUT (
    .ref_clk(ref_clk), .rst_b(rst_b), .por_b(por_b), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_rdata(cpu_rdata), .prog_rd(prog_rd),
    .prog_wr(prog_wr), .prog_addr(prog_addr), .prog_wdata(prog_wdata),
    .prog_rdata(prog_rdata), .trim_wr(trim_wr),
    .trim_coarse_wdata(trim_coarse_wdata), .trim_temp_wdata(trim_temp_wdata),
    .watchdog_control(watchdog_control), .brownout_control(brownout_control),
    .oscillator_control(oscillator_control), .cpu_rst_hold(cpu_rst_hold));

  fcl_programmer PRG (.ref_clk(ref_clk), .prog_rd(prog_rd), .prog_wr(prog_wr),
    .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      close_out();
    end
  end

  task automatic close_out();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : close_out

  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [19:0] osc_exp(input logic [7:0] f);
    logic s;
    s = (f[1:0] == fcl_pkg::FCL_FREQ_16M);
    osc_exp = {f[7], f[1:0], s, s ? {C16C, C16T} : {C20C, C20T}};
  endfunction : osc_exp

  task automatic cpu_read(input logic [5:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    cpu_rd   <= 1'h1;
    cpu_addr <= a;
    @(posedge ref_clk);
    cpu_rd   <= 1'h0;
    cpu_addr <= ~a;
    @(negedge ref_clk);
    chk(20'(cpu_rdata), 20'(exp));
  endtask : cpu_read

  // power-on writes the brown-out fuse on the first edge after release
  task automatic do_reset(input logic por, input logic [7:0] b);
    int k;
    @(posedge ref_clk);
    rst_b <= 1'h0;
    por_b <= ~por;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'h1;
    por_b <= 1'h1;
    if (por) PRG.wr(1'h0, 6'h01, b);
    k = 0;
    while (cpu_rst_hold !== 1'h0 && k < 20) begin
      @(negedge ref_clk);
      k++;
    end
    chk(20'(k < 20), 20'h1);
  endtask : do_reset

  initial begin
    logic [7:0]  d;
    logic [7:0]  w;
    logic [7:0]  b;
    logic [7:0]  o;
    logic [7:0]  wp;
    logic [7:0]  bp;
    logic [19:0] e;
    int          i;
    rst_b = 1'h0;
    por_b = 1'h0;
    cpu_rd = 1'h0;
    cpu_addr = 6'h00;
    trim_wr = 1'h0;
    trim_coarse_wdata = 8'h00;
    trim_temp_wdata = 8'h00;
    i = $urandom(32'hb051);
    do_reset(1'h1, 8'h00);
    wp = 8'h00;
    bp = 8'h00;
    chk(20'(oscillator_control), osc_exp(8'h02));
    cpu_read(6'h23, 8'h91);
    cpu_read(6'h24, 8'h92);
    cpu_read(6'h25, 8'h93);
    cpu_read(6'h05, fcl_pkg::FCL_RST_SYS0);
    PRG.wr(1'h1, 6'h09, 8'h5a);
    cpu_read(6'h09, 8'h00);
    for (i = 0; i < 8; i++) begin
      w = 8'($urandom);
      b = {3'($urandom), 1'($urandom), i[2:1], i[2:1]};
      o = {i[1], 5'h00, i[2:1]};
      PRG.wr(1'h1, 6'h00, w);
      PRG.wr(1'h1, 6'h01, b);
      PRG.wr(1'h1, 6'h02, o);
      PRG.rd(6'h02, d);
      chk(20'(d), 20'(o | 8'h7c));
      cpu_read(6'h00, w);
      chk(20'(watchdog_control), 20'(wp));
      do_reset(i[0], b);
      if (i[0]) begin
        w = 8'h00;
        o = 8'h02;
        bp = b;
      end
      chk(20'(watchdog_control), 20'(w));
      chk(20'(brownout_control), 20'(bp));
      e = osc_exp(o);
      chk(20'(oscillator_control), e);
      @(posedge ref_clk);
      trim_wr <= 1'h1;
      trim_coarse_wdata <= 8'($urandom);
      trim_temp_wdata <= 8'($urandom);
      @(posedge ref_clk);
      trim_wr <= 1'h0;
      if (!o[7]) e[15:0] = {trim_coarse_wdata, trim_temp_wdata};
      @(negedge ref_clk);
      chk(20'(oscillator_control), e);
      wp = w;
    end
    close_out();
  end
endmodule : fcl_fuse_config_loader_test

`default_nettype wire
